// ==== common/irq_seq_pkg.sv ====
// constants for the cpu interrupt sequencer
// assumes a single cpu clock and a nine bit program counter
package irq_seq_pkg;
  localparam int PC_W = 9;
  localparam int SP_W = 8;
  localparam int NUM_SRC = 9;
  localparam int SRC_W = 4;
  // vector 0 is reset, sources 0..NUM_SRC-1 sit at vectors 1..NUM_SRC
  localparam logic [8:0] RESET_VECTOR = 9'h000;
  localparam logic [8:0] FIRST_SRC_VECTOR = 9'h001;
  localparam logic [7:0] SP_RESET = 8'h9F;
  localparam logic [7:0] SP_STEP = 8'h02;
  localparam int CLK_MHZ = 125;
  localparam int ENTRY_CYCLES = 4;
  localparam int WAKE_EXTRA_CYCLES = 4;
  localparam int RETURN_CYCLES = 4;
  localparam int JUMP_CYCLES = 3;
  localparam logic [3:0] ENTRY_LEN = 4'h4;
  localparam logic [3:0] WAKE_EXTRA_LEN = 4'h4;
  localparam logic [3:0] RETURN_LEN = 4'h4;
  localparam logic [3:0] JUMP_LEN = 4'h3;
  localparam logic [3:0] PUSH_LO_STEP = 4'h1;
  localparam logic [3:0] PUSH_HI_STEP = 4'h2;
  localparam logic [3:0] POP_HI_STEP = 4'h1;
  localparam logic [3:0] POP_LO_STEP = 4'h2;
  typedef enum logic [5:0] {
    ST_RUN    = 6'h01,
    ST_WAKE   = 6'h02,
    ST_ENTRY  = 6'h04,
    ST_JUMP   = 6'h08,
    ST_RETURN = 6'h10,
    ST_GUARD  = 6'h20
  } seq_state_e;
endpackage

// ==== design/irq_priority_pick.sv ====
// fixed priority picker: lowest index wins
// assumes request vector is already gated by enables
`timescale 1ns/100ps
`default_nettype none
module irq_priority_pick #(
  parameter int N = 9,
  parameter int W = 4
) (
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [W-1:0] idx_o,
  output logic [N-1:0] onehot_o
);
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    onehot_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = W'(i);
        onehot_o = N'(1) << i;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/irq_flag_bank.sv ====
// pending flag bank for flag-type interrupt sources
// assumes event inputs are already synchronised to clk_i
`timescale 1ns/100ps
`default_nettype none
module irq_flag_bank #(
  parameter int N = 9
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [N-1:0] event_i,
  input wire logic [N-1:0] sw_clear_i,
  input wire logic [N-1:0] hw_clear_i,
  output logic [N-1:0] flag_o
);
  logic [N-1:0] next_flag;
  // set wins over either clear; enables do not gate setting
  assign next_flag = event_i | (flag_o & ~sw_clear_i & ~hw_clear_i);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= next_flag;
    end
  end
endmodule
`default_nettype wire

// ==== design/cpu_interrupt_sequencer.sv ====
// interrupt acceptance and sequencing between peripherals and the cpu pipeline
// assumes one cpu clock; pipeline handshakes are on clk_i, source pins are asynchronous
// Function
// - take a source only when its enable and global enable are both set
// - vectors at lowest addresses, lower address wins, reset first, request zero next
// - accepting an interrupt clears global enable
// - software may set global enable in a handler, allowing nesting
// - return from handler sets global enable
// - flag interrupts vector the pc and clear their flag on acceptance
// - writing one clears a pending flag, zero leaves it
// - flags set while disabled are held until enabled or cleared
// - flags held while globally disabled are served later by priority
// - level interrupts request only while present, never latched
// - one instruction of the main program runs after return first
// - status flags are not saved or restored by hardware
// - clear global enable blocks interrupts at once, same cycle too
// - after set global enable the next instruction runs first
// - entry takes four cycles pushing the pc, then vector runs
// - the vector jump takes three cycles to reach the handler
// - interrupt waits for a multi-cycle instruction to finish
// - wake from sleep adds four cycles beyond the sleep start-up
// - return takes four cycles, pops pc, sp plus two, sets enable
// - program counter and vectors are nine bits wide
// - pushing return address lowers stack pointer by two
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_sequencer #(
  parameter int NUM_SRC = irq_seq_pkg::NUM_SRC,
  parameter logic [NUM_SRC-1:0] LEVEL_TYPE = '0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // asynchronous source conditions; flag sources are events, level ones are conditions
  input wire logic [NUM_SRC-1:0] src_cond_i,
  input wire logic [NUM_SRC-1:0] src_enable_i,
  input wire logic [NUM_SRC-1:0] flag_clear_i,
  // pipeline status, all on clk_i
  input wire logic instr_done_i,
  input wire logic set_global_enable_i,
  input wire logic clear_global_enable_i,
  input wire logic return_from_handler_instr_i,
  input wire logic sleeping_i,
  input wire logic wake_ready_i,
  input wire logic [8:0] program_counter_i,
  input wire logic [7:0] pop_data_i,
  output logic global_enable_o,
  output logic [NUM_SRC-1:0] pending_flag_o,
  output logic hold_pipeline_o,
  output logic entry_start_o,
  output logic [8:0] program_counter_o,
  output logic pc_load_o,
  output logic [7:0] stack_pointer_o,
  output logic push_valid_o,
  output logic [7:0] push_data_o,
  output logic [7:0] push_addr_o,
  output logic pop_req_o,
  output logic [7:0] pop_addr_o,
  output logic vector_jump_o,
  output logic [3:0] active_src_o,
  output logic in_handler_o
);
  localparam int SW = irq_seq_pkg::SRC_W;

  // synchronise source pins
  logic [NUM_SRC-1:0] cond_meta;
  logic [NUM_SRC-1:0] cond_sync;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cond_meta <= '0;
      cond_sync <= '0;
    end else begin
      cond_meta <= src_cond_i;
      cond_sync <= cond_meta;
    end
  end

  // flag-type sources latch on a rising condition
  logic [NUM_SRC-1:0] cond_prev;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cond_prev <= '0;
    end else begin
      cond_prev <= cond_sync;
    end
  end
  wire [NUM_SRC-1:0] flag_event = cond_sync & ~cond_prev & ~LEVEL_TYPE;

  logic [NUM_SRC-1:0] hw_clear;
  logic [NUM_SRC-1:0] flags;
  irq_flag_bank #(.N(NUM_SRC)) u_flags (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(flag_event),
    .sw_clear_i(flag_clear_i & ~LEVEL_TYPE),
    .hw_clear_i(hw_clear),
    .flag_o(flags)
  );
  assign pending_flag_o = flags;

  // flags latch; level sources pass only while present
  wire [NUM_SRC-1:0] raw_req = (flags & ~LEVEL_TYPE) | (cond_sync & LEVEL_TYPE);
  wire [NUM_SRC-1:0] enabled_req = raw_req & src_enable_i;

  logic pick_any;
  logic [SW-1:0] pick_idx;
  logic [NUM_SRC-1:0] pick_onehot;
  irq_priority_pick #(.N(NUM_SRC), .W(SW)) u_pick (
    .req_i(enabled_req),
    .any_o(pick_any),
    .idx_o(pick_idx),
    .onehot_o(pick_onehot)
  );

  function automatic logic [8:0] vector_of(input logic [SW-1:0] idx);
    vector_of = irq_seq_pkg::FIRST_SRC_VECTOR + 9'(idx);
  endfunction

  irq_seq_pkg::seq_state_e state;
  irq_seq_pkg::seq_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic gie;
  logic next_gie;
  logic guard; // one instruction must complete before acceptance
  logic next_guard;
  logic [8:0] ret_pc;
  logic [8:0] next_ret_pc;
  logic [8:0] vec_pc;
  logic [8:0] next_vec_pc;
  logic [7:0] sp;
  logic [7:0] next_sp;
  logic [3:0] act_src;
  logic [3:0] next_act_src;
  logic [7:0] depth;
  logic [7:0] next_depth;

  // clear wins same cycle; set and guard suppress acceptance
  wire can_accept = gie && !clear_global_enable_i && !set_global_enable_i && !guard;
  // wait for instruction boundary or sleep
  wire boundary = instr_done_i || sleeping_i;
  wire accept = (state == irq_seq_pkg::ST_RUN) && can_accept && pick_any && boundary;
  wire start_return = (state == irq_seq_pkg::ST_RUN) && return_from_handler_instr_i && !accept;

  assign hw_clear = (accept ? pick_onehot : '0) & ~LEVEL_TYPE;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_gie = gie;
    next_guard = guard;
    next_ret_pc = ret_pc;
    next_vec_pc = vec_pc;
    next_sp = sp;
    next_act_src = act_src;
    next_depth = depth;
    if (guard && instr_done_i) begin
      next_guard = 1'b0;
    end
    if (set_global_enable_i) begin
      next_gie = 1'b1;
      next_guard = 1'b1;
    end
    case (state)
      irq_seq_pkg::ST_RUN: begin
        if (accept) begin
          next_gie = 1'b0;
          next_ret_pc = program_counter_i;
          next_vec_pc = vector_of(pick_idx);
          next_act_src = pick_idx;
          next_cnt = '0;
          next_depth = depth + 8'h01;
          next_state = sleeping_i ? irq_seq_pkg::ST_WAKE : irq_seq_pkg::ST_ENTRY;
        end else if (start_return) begin
          next_cnt = '0;
          next_state = irq_seq_pkg::ST_RETURN;
        end
      end
      irq_seq_pkg::ST_WAKE: begin
        // start-up of the sleep mode first, then four extra cycles
        if (wake_ready_i || cnt != '0) begin
          next_cnt = cnt + 4'h1;
          if (cnt + 4'h1 == irq_seq_pkg::WAKE_EXTRA_LEN) begin
            next_cnt = '0;
            next_state = irq_seq_pkg::ST_ENTRY;
          end
        end
      end
      irq_seq_pkg::ST_ENTRY: begin
        next_cnt = cnt + 4'h1;
        if (cnt == irq_seq_pkg::PUSH_LO_STEP || cnt == irq_seq_pkg::PUSH_HI_STEP) begin
          next_sp = sp - 8'h01; // two bytes pushed, sp lowered by two
        end
        if (cnt + 4'h1 == irq_seq_pkg::ENTRY_LEN) begin
          next_cnt = '0;
          next_state = irq_seq_pkg::ST_JUMP;
        end
      end
      irq_seq_pkg::ST_JUMP: begin
        next_cnt = cnt + 4'h1;
        if (cnt + 4'h1 == irq_seq_pkg::JUMP_LEN) begin
          next_cnt = '0;
          next_state = irq_seq_pkg::ST_RUN;
        end
      end
      irq_seq_pkg::ST_RETURN: begin
        next_cnt = cnt + 4'h1;
        // sp steps in the pop request cycles so the second read sees the raised pointer
        if (cnt == irq_seq_pkg::POP_HI_STEP - 4'h1 || cnt == irq_seq_pkg::POP_LO_STEP - 4'h1) begin
          next_sp = sp + 8'h01;
        end
        if (cnt == irq_seq_pkg::POP_HI_STEP) begin
          next_ret_pc = {pop_data_i[0], ret_pc[7:0]};
        end
        if (cnt == irq_seq_pkg::POP_LO_STEP) begin
          next_ret_pc = {ret_pc[8], pop_data_i};
        end
        if (cnt + 4'h1 == irq_seq_pkg::RETURN_LEN) begin
          next_cnt = '0;
          next_gie = 1'b1;
          next_guard = 1'b1;
          next_depth = (depth == 8'h00) ? 8'h00 : depth - 8'h01;
          next_state = irq_seq_pkg::ST_GUARD;
        end
      end
      irq_seq_pkg::ST_GUARD: begin
        // pc reload cycle, back to the main program
        next_state = irq_seq_pkg::ST_RUN;
      end
      default: begin
        next_state = irq_seq_pkg::ST_RUN;
      end
    endcase
    // clear wins over every set, the return path included
    if (clear_global_enable_i) begin
      next_gie = 1'b0;
    end
  end

  // status flags other than global enable are never touched here
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= irq_seq_pkg::ST_JUMP;
      cnt <= '0;
      gie <= 1'b0;
      guard <= 1'b0;
      ret_pc <= '0;
      vec_pc <= irq_seq_pkg::RESET_VECTOR; // reset has its own vector, highest rank
      sp <= irq_seq_pkg::SP_RESET;
      act_src <= '0;
      depth <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      gie <= next_gie;
      guard <= next_guard;
      ret_pc <= next_ret_pc;
      vec_pc <= next_vec_pc;
      sp <= next_sp;
      act_src <= next_act_src;
      depth <= next_depth;
    end
  end

  wire in_entry = (state == irq_seq_pkg::ST_ENTRY);
  wire in_return = (state == irq_seq_pkg::ST_RETURN);
  wire push_lo = in_entry && cnt == irq_seq_pkg::PUSH_LO_STEP;
  wire push_hi = in_entry && cnt == irq_seq_pkg::PUSH_HI_STEP;

  assign hold_pipeline_o = (state != irq_seq_pkg::ST_RUN);
  assign entry_start_o = accept;
  assign global_enable_o = gie;
  assign push_valid_o = push_lo || push_hi;
  assign pop_req_o = in_return && (cnt == irq_seq_pkg::POP_HI_STEP - 4'h1 || cnt == irq_seq_pkg::POP_LO_STEP - 4'h1);
  assign vector_jump_o = (state == irq_seq_pkg::ST_JUMP);

  // data outputs registered
  logic [7:0] push_data;
  logic [7:0] push_addr;
  logic [7:0] pop_addr;
  logic [8:0] pc_out;
  logic pc_load;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      push_data <= '0;
      push_addr <= '0;
      pop_addr <= '0;
      pc_out <= irq_seq_pkg::RESET_VECTOR;
      pc_load <= 1'b0;
    end else begin
      push_data <= (cnt == irq_seq_pkg::PUSH_LO_STEP - 4'h1) ? ret_pc[7:0] : {7'h00, ret_pc[8]};
      push_addr <= next_sp;
      pop_addr <= next_sp + 8'h01;
      pc_load <= (in_entry && cnt + 4'h1 == irq_seq_pkg::ENTRY_LEN) || (state == irq_seq_pkg::ST_GUARD);
      pc_out <= (state == irq_seq_pkg::ST_GUARD) ? ret_pc : vec_pc;
    end
  end
  assign push_data_o = push_data;
  assign push_addr_o = push_addr;
  assign pop_addr_o = pop_addr;
  assign program_counter_o = pc_out;
  assign pc_load_o = pc_load;
  assign stack_pointer_o = sp;
  assign active_src_o = act_src;
  assign in_handler_o = (depth != 8'h00);
endmodule
`default_nettype wire

// ==== bench/irq_seq_checker.sv ====
// timing and gating assertions on the sequencer top ports
// assumes it is bound to cpu_interrupt_sequencer, single clock
`timescale 1ns/100ps
`default_nettype none
module irq_seq_checker #(
  parameter int NUM_SRC = 9,
  parameter logic [NUM_SRC-1:0] LEVEL_TYPE = '0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sleeping_i,
  input wire logic clear_global_enable_i,
  input wire logic set_global_enable_i,
  input wire logic return_from_handler_instr_i,
  input wire logic global_enable_o,
  input wire logic entry_start_o,
  input wire logic pc_load_o,
  input wire logic [8:0] program_counter_o,
  input wire logic push_valid_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic vector_jump_o,
  input wire logic [3:0] active_src_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  gie_drop_a: assert property (entry_start_o |=> !global_enable_o) else $error("gie kept on entry");
  gate_a: assert property (entry_start_o |-> global_enable_o && !clear_global_enable_i && !set_global_enable_i)
    else $error("entry while not allowed");
  cli_now_a: assert property (clear_global_enable_i |=> !global_enable_o) else $error("cli late");
  entry_time_a: assert property (entry_start_o && !sleeping_i |-> ##5 (pc_load_o && vector_jump_o) ##1 vector_jump_o [*2] ##1 !vector_jump_o)
    else $error("entry timing wrong");
  vector_pick_a: assert property (entry_start_o && !sleeping_i |->
    ##5 program_counter_o == {5'h00, active_src_o} + irq_seq_pkg::FIRST_SRC_VECTOR) else $error("wrong vector");
  push_pair_a: assert property (entry_start_o && !sleeping_i |-> ##[1:3] (push_valid_o ##1 push_valid_o))
    else $error("pc not pushed");
  sp_push_a: assert property (entry_start_o && !sleeping_i |->
    ##6 stack_pointer_o == $past(stack_pointer_o, 6) - irq_seq_pkg::SP_STEP) else $error("sp not lowered by two");
  ret_time_a: assert property (return_from_handler_instr_i |-> ##6 (pc_load_o && global_enable_o &&
    stack_pointer_o == $past(stack_pointer_o, 6) + irq_seq_pkg::SP_STEP)) else $error("return timing wrong");
  ret_guard_a: assert property (return_from_handler_instr_i |-> !entry_start_o [*7]) else $error("no guard");
  entry_c: cover property (entry_start_o && !sleeping_i);
  sleep_c: cover property (entry_start_o && sleeping_i);
  ret_c: cover property (return_from_handler_instr_i);
endmodule
bind cpu_interrupt_sequencer irq_seq_checker #(.NUM_SRC(NUM_SRC), .LEVEL_TYPE(LEVEL_TYPE)) irq_seq_checker_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sleeping_i(sleeping_i), .clear_global_enable_i(clear_global_enable_i),
  .set_global_enable_i(set_global_enable_i), .return_from_handler_instr_i(return_from_handler_instr_i),
  .global_enable_o(global_enable_o), .entry_start_o(entry_start_o), .pc_load_o(pc_load_o),
  .program_counter_o(program_counter_o), .push_valid_o(push_valid_o), .stack_pointer_o(stack_pointer_o),
  .vector_jump_o(vector_jump_o), .active_src_o(active_src_o));
`default_nettype wire

// ==== bench/cpu_pipe_model.sv ====
// cpu pipeline and stack memory model facing the sequencer
// assumes one-cycle instructions whenever the pipeline is neither held nor sleeping
`timescale 1ns/100ps
`default_nettype none
module cpu_pipe_model #(
  parameter int WAKE_DLY = 5
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hold_i,
  input wire logic sleeping_i,
  input wire logic pc_load_i,
  input wire logic [8:0] pc_i,
  input wire logic push_valid_i,
  input wire logic [7:0] push_addr_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_req_i,
  input wire logic [7:0] pop_addr_i,
  output logic instr_done_o,
  output logic wake_ready_o,
  output logic [8:0] program_counter_o,
  output logic [7:0] pop_data_o
);
  logic [7:0] stack_mem [0:255];
  logic [3:0] wake_cnt;
  assign instr_done_o = !hold_i && !sleeping_i;
  assign wake_ready_o = sleeping_i && (wake_cnt == WAKE_DLY[3:0]);
  always_ff @(posedge clk_i) begin
    if (push_valid_i) stack_mem[push_addr_i] <= push_data_i;
    wake_cnt <= (sleeping_i && !wake_ready_o) ? wake_cnt + 4'h1 : (sleeping_i ? wake_cnt : 4'h0);
    // released read bus shows the inverse of its last value
    if (sys_rst_i) pop_data_o <= 8'h00;
    else pop_data_o <= pop_req_i ? stack_mem[pop_addr_i] : ~pop_data_o;
    // start near the top so return addresses use bit 8
    if (sys_rst_i) program_counter_o <= 9'h1F0;
    else if (pc_load_i) program_counter_o <= pc_i;
    else if (instr_done_o) program_counter_o <= program_counter_o + 9'h001;
  end
endmodule
`default_nettype wire

// ==== bench/cpu_interrupt_sequencer_tb_top.sv ====
// self-checking bench: random flag bursts, level source, cli race, sleep wake
// assumes cpu_pipe_model as the pipeline and the bound checker
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_sequencer_tb_top;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, lvl = 1'b0, sleeping = 1'b0, armed = 1'b0;
  logic [2:0] ctl = 3'h0;
  logic [8:0] ev = 9'h000, src_en = 9'h000, flag_clr = 9'h000, m, cl, srv;
  logic [8:0] exp_q[$], ret_q[$];
  int fails = 0, checked = 0, k, s, r;
  wire logic hold, entry, pc_load, push_v, pop_r, done, wake, gie;
  wire logic [8:0] pending, pc_in, pc_out;
  wire logic [7:0] push_a, push_d, pop_a, pop_d;
  cpu_interrupt_sequencer #(.LEVEL_TYPE(9'h100)) cpu_interrupt_sequencer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .src_cond_i({lvl, ev[7:0]}), .src_enable_i(src_en), .flag_clear_i(flag_clr), .instr_done_i(done),
    .set_global_enable_i(ctl[2]), .clear_global_enable_i(ctl[1]), .return_from_handler_instr_i(ctl[0]),
    .sleeping_i(sleeping), .wake_ready_i(wake), .program_counter_i(pc_in), .pop_data_i(pop_d),
    .global_enable_o(gie), .pending_flag_o(pending), .hold_pipeline_o(hold), .entry_start_o(entry),
    .program_counter_o(pc_out), .pc_load_o(pc_load), .stack_pointer_o(), .push_valid_o(push_v),
    .push_data_o(push_d), .push_addr_o(push_a), .pop_req_o(pop_r), .pop_addr_o(pop_a), .vector_jump_o(),
    .active_src_o(), .in_handler_o());
  cpu_pipe_model cpu_pipe_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hold_i(hold), .sleeping_i(sleeping),
    .pc_load_i(pc_load), .pc_i(pc_out), .push_valid_i(push_v), .push_addr_i(push_a), .push_data_i(push_d),
    .pop_req_i(pop_r), .pop_addr_i(pop_a), .instr_done_o(done), .wake_ready_o(wake), .program_counter_o(pc_in),
    .pop_data_o(pop_d));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task check(input string what, input logic [8:0] seen, input logic [8:0] expv);
    checked++;
    if (seen !== expv) begin
      fails++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  // one-cycle strobes: {set gie, clear gie, return}, source events, flag clears
  task pulse(input logic [2:0] c, input logic [8:0] e, input logic [8:0] fc);
    tick;
    ctl = c;
    ev = e;
    flag_clr = fc;
    tick;
    ctl = 3'h0;
    ev = 9'h000;
    flag_clr = 9'h000;
  endtask
  // handler: expect the vector, drop the condition, return and expect the saved pc
  task serve(input int src);
    exp_q.push_back(irq_seq_pkg::FIRST_SRC_VECTOR + 9'(src));
    for (k = 0; k < 40 && pc_load !== 1'b1; k++) tick;
    sleeping = 1'b0;
    lvl = 1'b0;
    repeat (6) tick;
    pulse(3'b001, 9'h000, 9'h000);
    exp_q.push_back(ret_q.pop_back());
    // let the return reload pass before the next handler is awaited
    for (k = 0; k < 40 && pc_load !== 1'b1; k++) tick;
    tick;
  endtask
  always @(posedge clk_i) begin
    if (entry === 1'b1) ret_q.push_back(pc_in);
    if (armed && pc_load === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error pc_load expected none seen %h", pc_out);
      end else check("pc_load", pc_out, exp_q.pop_front());
    end
  end
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h19cafaac));
    repeat (3) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (6) tick;
    armed = 1'b1;
    check("gie_reset", {8'h00, gie}, 9'h000);
    check("pending_reset", pending, 9'h000);
    for (r = 0; r < 6; r++) begin
      m = 9'($urandom) & 9'h0FF | 9'h001;
      cl = m & 9'($urandom) & 9'h0FE;
      src_en = {1'b1, 8'($urandom)};
      pulse(3'b000, m, 9'h000);
      repeat (4) tick;
      check("pending_held", pending, m);
      pulse(3'b000, 9'h000, cl);
      tick;
      check("pending_clr", pending, m & ~cl);
      srv = m & ~cl & src_en;
      pulse(3'b100, 9'h000, 9'h000);
      for (s = 0; s < 8; s++) if (srv[s]) serve(s);
      repeat (8) tick;
      check("pending_left", pending, m & ~cl & ~src_en);
      pulse(3'b010, 9'h000, 9'h1FF);
    end
    src_en = 9'h1FF;
    lvl = 1'b1;
    repeat (3) tick;
    lvl = 1'b0;
    pulse(3'b100, 9'h000, 9'h000);
    repeat (20) tick;
    lvl = 1'b1;
    serve(8);
    repeat (8) tick;
    pulse(3'b010, 9'h004, 9'h000);
    repeat (10) tick;
    check("pending_cli", pending, 9'h004);
    pulse(3'b100, 9'h000, 9'h004);
    tick;
    sleeping = 1'b1;
    pulse(3'b000, 9'h001, 9'h000);
    serve(0);
    repeat (12) tick;
    check("gie_after_return", {8'h00, gie}, 9'h001);
    check("queue_empty", 9'(exp_q.size()), 9'h000);
    complete_run();
  end
endmodule
`default_nettype wire
